// [core/active_antenna_supervisor.sv]
// active antenna supervisor: supply switch control, short and presence sensing
// assumes synchronous apb master on clock, sense inputs asynchronous to clock
`timescale 1ns/100ps

module active_antenna_supervisor #(
  parameter int retry_cycles = ant_sup_pkg::retry_cycles
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // antenna pins
  input  wire logic        fault_sense_in_n,
  input  wire logic        presence_sense_in,
  output logic             supply_cut_out,
  // interrupt
  output logic             irq
);

  ant_sup_pkg::sup_state_s s_q;
  ant_sup_pkg::sup_state_s s_d;

  // ----------------------------------------------------------------
  // derived conditions
  // ----------------------------------------------------------------
  logic        sup_on;
  logic        fault_on;
  logic        retry_on;
  logic        pres_on;
  logic        short_now;
  logic        absent_now;
  logic        wr;
  logic        rd;
  logic [1:0]  ant_stat;
  logic [2:0]  irq_set;
  logic [31:0] stat_word;

  always_comb begin
    sup_on     = s_q.cfg[ant_sup_pkg::cfg_supply_bit];
    fault_on   = sup_on && s_q.cfg[ant_sup_pkg::cfg_fault_bit];
    retry_on   = s_q.cfg[ant_sup_pkg::cfg_retry_bit];
    pres_on    = sup_on && s_q.cfg[ant_sup_pkg::cfg_presence_bit];
    short_now  = fault_on && !s_q.fault_sync2;
    absent_now = pres_on && !s_q.pres_sync2;
    wr         = psel && penable && pwrite && !s_q.pready;
    rd         = psel && penable && !pwrite && !s_q.pready;
    // short has priority over open; a present antenna reads ok
    if (!sup_on) begin
      ant_stat = ant_sup_pkg::ant_init;
    end else if (s_q.short_latched) begin
      ant_stat = ant_sup_pkg::ant_short;
    end else if (absent_now) begin
      ant_stat = ant_sup_pkg::ant_open;
    end else begin
      ant_stat = ant_sup_pkg::ant_ok;
    end
    stat_word = 32'h0000_0000;
    stat_word[1:0] = ant_stat;
    stat_word[ant_sup_pkg::st_power_bit] = sup_on && !s_q.cut;
    stat_word[ant_sup_pkg::st_valid_bit] = sup_on;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    irq_set = 3'h0;
    // two-flop synchronisers; only the second stage is used
    s_d.fault_sync1 = fault_sense_in_n;
    s_d.fault_sync2 = s_q.fault_sync1;
    s_d.pres_sync1  = presence_sense_in;
    s_d.pres_sync2  = s_q.pres_sync1;
    s_d.fault_en_prev = fault_on;

    // bus: one wait state, answer in the second access cycle
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if ((wr || rd) && !(paddr == ant_sup_pkg::cfg_addr || paddr == ant_sup_pkg::status_addr
        || paddr == ant_sup_pkg::irq_addr || paddr == ant_sup_pkg::mask_addr)) begin
      s_d.pslverr = 1'b1;
    end
    if (rd) begin
      case (paddr)
        ant_sup_pkg::cfg_addr:    s_d.prdata = {27'h000_0000, s_q.cfg};
        ant_sup_pkg::status_addr: s_d.prdata = stat_word;
        ant_sup_pkg::irq_addr:    s_d.prdata = {29'h0000_0000, s_q.irq_status};
        ant_sup_pkg::mask_addr:   s_d.prdata = {29'h0000_0000, s_q.irq_mask};
        default:                  s_d.prdata = 32'h0000_0000;
      endcase
    end
    if (wr && paddr == ant_sup_pkg::cfg_addr) begin
      s_d.cfg = pwdata[4:0];
    end
    if (wr && paddr == ant_sup_pkg::mask_addr) begin
      s_d.irq_mask = pwdata[2:0];
    end

    // supervisor
    case (s_q.state)
      ant_sup_pkg::st_idle: begin
        s_d.cut = 1'b0;
        s_d.short_latched = 1'b0;
        if (sup_on) begin
          s_d.state = ant_sup_pkg::st_run;
        end
      end
      ant_sup_pkg::st_run: begin
        // turning fault detect on again clears a latched short
        if (fault_on && !s_q.fault_en_prev) begin
          s_d.short_latched = 1'b0;
        end
        if (!fault_on) begin
          s_d.short_latched = 1'b0;
        end
        if (short_now) begin
          if (!s_q.short_latched) begin
            irq_set[ant_sup_pkg::irq_short_bit] = 1'b1;
          end
          s_d.short_latched = 1'b1;
          if (retry_on || s_q.cfg[ant_sup_pkg::cfg_pdof_bit]) begin
            s_d.cut   = 1'b1;
            s_d.timer = 32'h0000_0000;
            s_d.state = ant_sup_pkg::st_cut;
          end
        end
        // level source: the bit comes back after a clear while the antenna stays absent
        if (absent_now) begin
          irq_set[ant_sup_pkg::irq_open_bit] = 1'b1;
        end
        if (!sup_on) begin
          s_d.state = ant_sup_pkg::st_idle;
        end
      end
      ant_sup_pkg::st_cut: begin
        s_d.cut = 1'b1;
        if (retry_on) begin
          s_d.timer = s_q.timer + 32'h0000_0001;
          if (s_q.timer == 32'(retry_cycles - 1)) begin
            // supply back on to retest; the run state re-latches a lasting short
            s_d.cut = 1'b0;
            s_d.short_latched = 1'b0;
            irq_set[ant_sup_pkg::irq_retry_bit] = 1'b1;
            s_d.state = ant_sup_pkg::st_run;
          end
        end
        // without retry the supply stays cut until fault detect or supply control is turned off, or reset
        if (!fault_on) begin
          s_d.cut = 1'b0;
          s_d.short_latched = 1'b0;
          s_d.state = ant_sup_pkg::st_run;
        end
        if (!sup_on) begin
          s_d.state = ant_sup_pkg::st_idle;
        end
      end
      default: begin
        s_d.state = ant_sup_pkg::st_idle;
      end
    endcase

    // sticky irq bits: set wins over write-one-to-clear
    if (wr && paddr == ant_sup_pkg::irq_addr) begin
      s_d.irq_status = s_q.irq_status & ~pwdata[2:0];
    end
    s_d.irq_status = s_d.irq_status | irq_set;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s_q <= '{fault_sync1: 1'b1, fault_sync2: 1'b1, pres_sync1: 1'b1, pres_sync2: 1'b1,
               cfg: ant_sup_pkg::cfg_reset, state: ant_sup_pkg::st_idle,
               short_latched: 1'b0, fault_en_prev: 1'b0, timer: 32'h0000_0000,
               cut: 1'b0, irq_status: ant_sup_pkg::irq_reset,
               irq_mask: ant_sup_pkg::irq_reset, irq: 1'b0, pready: 1'b0,
               prdata: 32'h0000_0000, pslverr: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign pready         = s_q.pready;
  assign prdata         = s_q.prdata;
  assign pslverr        = s_q.pslverr;
  assign supply_cut_out = s_q.cut;
  assign irq            = s_q.irq;

endmodule

// [core/ant_sup_pkg.sv]
// package for the active antenna supervisor: register map, fields, states, timing
// assumes a 10 MHz clock and an apb master with 32-bit data
package ant_sup_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] cfg_addr    = 8'h00;
  localparam logic [7:0] status_addr = 8'h04;
  localparam logic [7:0] irq_addr    = 8'h08;
  localparam logic [7:0] mask_addr   = 8'h0c;

  // cfg fields
  localparam int cfg_supply_bit   = 0;
  localparam int cfg_fault_bit    = 1;
  localparam int cfg_retry_bit    = 2;
  localparam int cfg_presence_bit = 3;
  localparam int cfg_pdof_bit     = 4;
  localparam logic [4:0] cfg_reset = 5'h00;

  // status fields: [1:0] antenna status, [2] power on, [3] reporting valid
  localparam int st_power_bit = 2;
  localparam int st_valid_bit = 3;

  // irq fields: [0] short seen, [1] open seen, [2] retry done
  localparam int irq_short_bit = 0;
  localparam int irq_open_bit  = 1;
  localparam int irq_retry_bit = 2;
  localparam logic [2:0] irq_reset = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int clock_hz        = 10_000_000;
  localparam int retry_ms        = 1000;
  localparam int retry_cycles    = retry_ms * (clock_hz / 1000);

  typedef enum logic [1:0] {
    ant_ok    = 2'b00,
    ant_short = 2'b01,
    ant_open  = 2'b10,
    ant_init  = 2'b11
  } ant_status_e;

  // gray along idle -> run -> cut -> back to run
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_run  = 2'b01,
    st_cut  = 2'b11
  } sup_state_e;

  typedef struct packed {
    logic        fault_sync1;
    logic        fault_sync2;
    logic        pres_sync1;
    logic        pres_sync2;
    logic [4:0]  cfg;
    sup_state_e  state;
    logic        short_latched;
    logic        fault_en_prev;
    logic [31:0] timer;
    logic        cut;
    logic [2:0]  irq_status;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } sup_state_s;

endpackage

// [testbench/ant_sup_props.sv]
// checker: bus handshake and supply switch timing of the antenna supervisor
// assumes only the top ports; cfg is mirrored from bus writes
`timescale 1ns/100ps

module ant_sup_props #(
  parameter int retry_cycles = 20
) (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        fault_sense_in_n,
  input wire logic        presence_sense_in,
  input wire logic        supply_cut_out,
  input wire logic        irq
);
  localparam int rlo = retry_cycles - 2;
  localparam int rhi = retry_cycles + 6;
  logic [4:0] cfg_q;
  logic       cut_ok;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // mirror of the config word, written on the first access cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) cfg_q <= 5'h00;
    else if (psel && penable && pwrite && !pready && paddr == ant_sup_pkg::cfg_addr)
      cfg_q <= pwdata[4:0];
  end
  assign cut_ok = cfg_q[1:0] == 2'b11 && (cfg_q[2] || cfg_q[4]);
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_answer_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ctrl_off_a: assert property (!cfg_q[0] [*2] |-> !supply_cut_out)
    else $error("supply cut while control disabled");
  cut_never_a: assert property (!cfg_q[2] && !cfg_q[4] && !supply_cut_out |=> !supply_cut_out)
    else $error("supply cut without power down");
  sync_delay_a: assert property ($fell(fault_sense_in_n) && !supply_cut_out
    |=> !supply_cut_out [*2])
    else $error("cut before sense synchronised");
  cut_rise_a: assert property ($fell(fault_sense_in_n) && cut_ok |-> ##[3:6] supply_cut_out)
    else $error("short did not cut supply");
  retry_drop_a: assert property ($rose(supply_cut_out) && cfg_q[2]
    |-> ##[rlo:rhi] !supply_cut_out)
    else $error("retry did not restore supply");
  cover property ($rose(supply_cut_out));
  cover property ($fell(supply_cut_out));
  cover property (pslverr);
endmodule

bind active_antenna_supervisor ant_sup_props #(.retry_cycles(retry_cycles)) u_props (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .fault_sense_in_n(fault_sense_in_n), .presence_sense_in(presence_sense_in),
  .supply_cut_out(supply_cut_out), .irq(irq));

// [testbench/ant_model.sv]
// behavioural antenna: supply switch, load and the two sense lines
// assumes the bench commands a short or a missing antenna
`timescale 1ns/100ps

module ant_model (
  // supply switch
  input  wire logic supply_cut_out,
  // scenario commands
  input  wire logic shorted,
  input  wire logic present,
  // sense lines
  output logic      fault_sense_in_n,
  output logic      presence_sense_in
);
  // unpowered antenna draws nothing, so the pull-up wins
  assign fault_sense_in_n  = !(shorted && !supply_cut_out);
  assign presence_sense_in = present && !supply_cut_out;
endmodule

// [testbench/active_antenna_supervisor_bench.sv]
// bench: bus-driven tests of the antenna supervisor with a behavioural antenna
// assumes package, checker and antenna model are compiled first
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module active_antenna_supervisor_bench;
  logic        clock, reset, psel, penable, pwrite, pready, pslverr, irq, e;
  logic        fault_sense_in_n, presence_sense_in, supply_cut_out, shorted, present;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          errors, num_checks, n;

  active_antenna_supervisor #(.retry_cycles(20)) u_dut (.clock, .reset, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .fault_sense_in_n,
    .presence_sense_in, .supply_cut_out, .irq);
  ant_model u_ant (.supply_cut_out, .shorted, .present, .fault_sense_in_n, .presence_sense_in);

  initial begin
    clock = 0;
    forever #50 clock = ~clock;
  end

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // bus access
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 10);
    if (k >= 10) begin errors++; $display("Error %0t: no pready", $time); end_sim(); end
    q = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask
  task automatic rd(input logic [7:0] a); apb(0, a, 32'h0000_0000); endtask
  task automatic cfg(input logic [4:0] d); wr(ant_sup_pkg::cfg_addr, {27'h000_0000, d}); endtask
  task automatic pause(input int c); repeat (c) @(posedge clock); endtask
  // sense path needs a few cycles through the synchronisers
  task automatic stat(input logic [1:0] c, input logic p);
    pause(8); rd(ant_sup_pkg::status_addr); `CHK(q[3:0], {1'b1, p, c})
  endtask

  initial begin
    reset = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0000_0000;
    shorted = 0; present = 1; errors = 0; num_checks = 0;
    pause(4);
    reset <= 0;
    rd(ant_sup_pkg::cfg_addr); `CHK(q, 32'h0000_0000)
    rd(ant_sup_pkg::status_addr); `CHK({q[3], q[1:0]}, 3'h3)
    `CHK(supply_cut_out, 1'b0)
    rd(8'h10); `CHK({e, q}, {1'b1, 32'h0000_0000})
    $display("reset test done");
    cfg(5'h01); rd(ant_sup_pkg::cfg_addr); `CHK(q, 32'h0000_0001)
    stat(ant_sup_pkg::ant_ok, 1);
    $display("control test done");
    cfg(5'h03); wr(ant_sup_pkg::mask_addr, 32'h0000_0001); shorted <= 1;
    stat(ant_sup_pkg::ant_short, 1);
    `CHK({irq, supply_cut_out}, 2'b10)
    wr(ant_sup_pkg::mask_addr, 32'h0000_0000); pause(2); `CHK(irq, 1'b0)
    shorted <= 0; stat(ant_sup_pkg::ant_short, 1);
    cfg(5'h01); cfg(5'h03); stat(ant_sup_pkg::ant_ok, 1);
    wr(ant_sup_pkg::irq_addr, 32'h0000_0007); wr(ant_sup_pkg::mask_addr, 32'h0000_0001);
    pause(2); `CHK(irq, 1'b0)
    $display("short test done");
    cfg(5'h13); shorted <= 1; stat(ant_sup_pkg::ant_short, 0);
    `CHK(supply_cut_out, 1'b1)
    shorted <= 0; cfg(5'h01); pause(4); `CHK(supply_cut_out, 1'b0)
    cfg(5'h07); shorted <= 1; stat(ant_sup_pkg::ant_short, 0);
    `CHK(supply_cut_out, 1'b1)
    shorted <= 0;
    n = 0;
    while (supply_cut_out === 1'b1 && n < 40) begin @(posedge clock); n++; end
    if (n >= 40) begin errors++; $display("Error %0t: cut stuck", $time); end_sim(); end
    stat(ant_sup_pkg::ant_ok, 1);
    $display("retry test done");
    cfg(5'h09); present <= 0; stat(ant_sup_pkg::ant_open, 1);
    present <= 1; stat(ant_sup_pkg::ant_ok, 1);
    rd(ant_sup_pkg::irq_addr); `CHK(q[2:0], 3'h7)
    $display("open test done");
    cfg(5'h03); shorted <= 1; stat(ant_sup_pkg::ant_short, 1);
    @(posedge clock); reset <= 1; pause(2); reset <= 0;
    rd(ant_sup_pkg::status_addr); `CHK({q[3], q[1:0]}, 3'h3)
    `CHK({irq, supply_cut_out}, 2'b00)
    $display("power cycle test done");
    end_sim();
  end
endmodule
